// ---- core/rsc_defs.vh ----
// Constants for the rail sequencer and color strobe block
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH
`define RSC_CLK_HZ 25000000
// Register indices on the configuration port
`define RSC_REG_CODE_A 8'h00
`define RSC_REG_CODE_B 8'h01
`define RSC_REG_CODE_C 8'h02
`define RSC_REG_DEAD_TIME 8'h0B
`define RSC_REG_STATUS 8'h10
`define RSC_DEAD_TIME_RST 8'h01
`define RSC_CODE_RST 10'h000
// Timing figures in their own units
`define RSC_INIT_MS 5
`define RSC_OFS_TO_BIAS_MS 145
`define RSC_PWR_DEGLITCH_US 1000
`define RSC_SEL_DEGLITCH_NS 300
`define RSC_STEP_MS 1
// Cycle counts derived from the rate
`define RSC_INIT_CYC ((`RSC_CLK_HZ / 1000) * `RSC_INIT_MS)
`define RSC_BIAS_CYC ((`RSC_CLK_HZ / 1000) * `RSC_OFS_TO_BIAS_MS)
`define RSC_PWR_DG_CYC ((`RSC_CLK_HZ / 1000000) * `RSC_PWR_DEGLITCH_US)
`define RSC_SEL_DG_CYC ((`RSC_SEL_DEGLITCH_NS * (`RSC_CLK_HZ / 1000000) + 999) / 1000)
`define RSC_STEP_CYC ((`RSC_CLK_HZ / 1000) * `RSC_STEP_MS)
// Status bit positions
`define RSC_ST_RAILS_UP 0
`define RSC_ST_FAULT 1
`define RSC_ST_STROBE_EN 2
`define RSC_VLED_DEFAULT_MV 16'h0DAC
`endif

// ---- core/rsc_code_mem.v ----
// Small register file holding the three per-color current codes
`timescale 1ns/100ps
`include "rsc_defs.vh"
module rsc_code_mem #(
   parameter WIDTH = 10,
   parameter DEPTH = 3
) (
   input wire mclk_i,
   input wire reset_i,
   input wire wr_en_i,
   input wire [1:0] wr_addr_i,
   input wire [WIDTH-1:0] wr_data_i,
   input wire [1:0] rd_addr_i,
   output reg [WIDTH-1:0] rd_data_o
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   genvar gi;
   // One word per color, cleared at reset so no stale current is driven
   generate
      for (gi = 0; gi < DEPTH; gi = gi + 1) begin : g_word
         always @(posedge mclk_i) begin
            if (reset_i) begin
               mem_r[gi] <= `RSC_CODE_RST;
            end else if (wr_en_i && wr_addr_i == gi) begin
               mem_r[gi] <= wr_data_i;
            end
         end
      end
   endgenerate
   // Registered read; unused addresses read zero
   always @(posedge mclk_i) begin
      if (reset_i) begin
         rd_data_o <= {WIDTH{1'b0}};
      end else if (rd_addr_i < DEPTH) begin
         rd_data_o <= mem_r[rd_addr_i];
      end else begin
         rd_data_o <= {WIDTH{1'b0}};
      end
   end
endmodule

// ---- core/rsc_top.v ----
// Rail sequencer and color strobe decoder with configuration port
// Notes on behaviour
// - After power request rises, initialise mirror array, then enable offset rail within 10 ms.
// - Wait 145 ms after offset rail, then enable bias and reset rails; a request dropped in S_INIT or S_OFS pulses them for a cycle.
// - Strobe decoder and LED driver stay off until all three rails are on.
// - Power request falling starts the normal rail power-down sequence.
// - Any rail fault forces fast power-down discharging all three rails at once.
// - Color select 0 opens all; 1,2,3 close only switch a, b, c.
// - Route the selected color's own 10-bit current code; none for code 0.
// - Open switches that must open before closing any switch.
// - Dead time between opening and closing comes from the dead time register.
// - A switch staying closed is not opened during the dead time.
// - Configuration and per-channel 10-bit current codes are written over the port.
// - With all switches open, command converter to its 3.5 V default target.
// - Deglitch the power request for about 1 ms before acting.
// - Deglitch both color select bits for about 300 ns before decoding.
`timescale 1ns/100ps
`include "rsc_defs.vh"
module rsc_top #(
   parameter CODE_W = 10,
   parameter INIT_CYC = `RSC_INIT_CYC,
   parameter BIAS_CYC = `RSC_BIAS_CYC,
   parameter PWR_DG_CYC = `RSC_PWR_DG_CYC,
   parameter STEP_CYC = `RSC_STEP_CYC
) (
   input wire mclk_i,
   input wire reset_i,
   input wire power_request_i,
   input wire [3:0] rail_fault_i,
   input wire [1:0] color_select_i,
   input wire cfg_wr_i,
   input wire cfg_rd_i,
   input wire [7:0] cfg_addr_i,
   input wire [15:0] cfg_wdata_i,
   output reg [15:0] cfg_rdata_o,
   output reg mirror_init_o,
   output reg mirror_offset_rail_o,
   output reg mirror_bias_rail_o,
   output reg mirror_reset_rail_o,
   output reg rail_discharge_o,
   output reg cathode_switch_a_o,
   output reg cathode_switch_b_o,
   output reg cathode_switch_c_o,
   output reg [CODE_W-1:0] led_dac_code_o,
   output reg led_dac_en_o,
   output reg vled_default_o
);
   localparam S_OFF = 3'd0;
   localparam S_INIT = 3'd1;
   localparam S_OFS = 3'd2;
   localparam S_ON = 3'd3;
   localparam S_STOP = 3'd4;
   localparam S_DOWN = 3'd5;
   localparam S_FAST = 3'd6;
   localparam SEL_DG = `RSC_SEL_DG_CYC;

   // Decode of a color code into a one-hot switch set c,b,a
   function [2:0] sw_decode;
      input [1:0] code;
      begin
         case (code)
            2'h1: sw_decode = 3'b001;
            2'h2: sw_decode = 3'b010;
            2'h3: sw_decode = 3'b100;
            default: sw_decode = 3'b000;
         endcase
      end
   endfunction

   reg [2:0] pr_sync_r;
   reg pr_filt_r;
   reg [23:0] pr_cnt_r;
   reg [5:0] cs_sync_r;
   reg [1:0] cs_filt_r;
   reg [7:0] cs_cnt_r;
   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [23:0] seq_cnt_r;
   reg fault_r;
   reg [7:0] dead_time_r;
   reg [7:0] bbm_cnt_r;
   reg [1:0] pend_sel_r;
   reg strobe_en;
   wire [2:0] sw_now;
   wire [2:0] sw_tgt;
   wire [2:0] keep;
   wire mem_wr;
   wire [CODE_W-1:0] mem_rd;
   wire [1:0] mem_rd_addr;

   // Power request: three flops, change counts when the last two agree
   always @(posedge mclk_i) begin
      if (reset_i) begin
         pr_sync_r <= 3'b000;
         pr_filt_r <= 1'b0;
         pr_cnt_r <= 24'h000000;
      end else begin
         pr_sync_r <= {pr_sync_r[1:0], power_request_i};
         if (pr_sync_r[2] != pr_sync_r[1] || pr_sync_r[2] == pr_filt_r) begin
            pr_cnt_r <= 24'h000000;
         end else if (pr_cnt_r >= PWR_DG_CYC - 1) begin
            pr_filt_r <= pr_sync_r[2];
            pr_cnt_r <= 24'h000000;
         end else begin
            pr_cnt_r <= pr_cnt_r + 24'h000001;
         end
      end
   end

   // Color select deglitch; both bits must be stable for the filter time
   always @(posedge mclk_i) begin
      if (reset_i) begin
         cs_sync_r <= 6'h00;
         cs_filt_r <= 2'h0;
         cs_cnt_r <= 8'h00;
      end else begin
         cs_sync_r <= {cs_sync_r[3:0], color_select_i};
         if (cs_sync_r[5:4] != cs_sync_r[3:2] || cs_sync_r[5:4] == cs_filt_r) begin
            cs_cnt_r <= 8'h00;
         end else if (cs_cnt_r >= SEL_DG - 1) begin
            cs_filt_r <= cs_sync_r[5:4];
            cs_cnt_r <= 8'h00;
         end else begin
            cs_cnt_r <= cs_cnt_r + 8'h01;
         end
      end
   end

   // Next state of the rail sequencer; a rail fault wins over everything in every state but S_OFF and S_FAST
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_OFF: begin
            if (pr_filt_r && !fault_r) begin
               state_nxt = S_INIT;
            end
         end
         S_INIT: begin
            if (seq_cnt_r >= INIT_CYC - 1) begin
               state_nxt = S_OFS;
            end
         end
         S_OFS: begin
            if (seq_cnt_r >= BIAS_CYC - 1) begin
               state_nxt = S_ON;
            end
         end
         S_ON: begin
            if (!pr_filt_r) begin
               state_nxt = S_STOP;
            end
         end
         S_STOP: begin
            state_nxt = S_DOWN;
         end
         S_DOWN: begin
            if (seq_cnt_r >= STEP_CYC - 1) begin
               state_nxt = S_OFF;
            end
         end
         S_FAST: begin
            if (!pr_filt_r) begin
               state_nxt = S_OFF;
            end
         end
         default: state_nxt = S_OFF;
      endcase
      if (rail_fault_i != 4'h0 && state_r != S_OFF && state_r != S_FAST) begin
         state_nxt = S_FAST;
      end
      if ((state_r == S_INIT || state_r == S_OFS) && !pr_filt_r &&
          rail_fault_i == 4'h0) begin
         state_nxt = S_STOP;
      end
   end

   // Sequencer registers; fault stays latched until request drops
   always @(posedge mclk_i) begin
      if (reset_i) begin
         state_r <= S_OFF;
         seq_cnt_r <= 24'h000000;
         fault_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_nxt != state_r) begin
            seq_cnt_r <= 24'h000000;
         end else begin
            seq_cnt_r <= seq_cnt_r + 24'h000001;
         end
         if (state_nxt == S_FAST) begin
            fault_r <= 1'b1;
         end else if (!pr_filt_r && state_r == S_OFF) begin
            fault_r <= 1'b0;
         end
      end
   end

   // Rail enables; bias and reset come off first in a normal power-down
   always @(posedge mclk_i) begin
      if (reset_i) begin
         mirror_init_o <= 1'b0;
         mirror_offset_rail_o <= 1'b0;
         mirror_bias_rail_o <= 1'b0;
         mirror_reset_rail_o <= 1'b0;
         rail_discharge_o <= 1'b1;
      end else begin
         mirror_init_o <= (state_nxt == S_INIT);
         mirror_offset_rail_o <= (state_nxt == S_OFS) || (state_nxt == S_ON) ||
                                 (state_nxt == S_STOP) || (state_nxt == S_DOWN);
         mirror_bias_rail_o <= (state_nxt == S_ON) || (state_nxt == S_STOP);
         mirror_reset_rail_o <= (state_nxt == S_ON) || (state_nxt == S_STOP);
         // All three discharged together on a fault
         rail_discharge_o <= (state_nxt == S_FAST) || (state_nxt == S_OFF);
      end
   end

   // Strobe runs only with all rails up and no power-down under way; looking at
   // the next state opens the switches no later than the rails start to drop
   always @* begin
      strobe_en = (state_r == S_ON) && (state_nxt == S_ON) && mirror_bias_rail_o &&
                  mirror_reset_rail_o && mirror_offset_rail_o;
   end

   assign sw_now = {cathode_switch_c_o, cathode_switch_b_o, cathode_switch_a_o};
   assign sw_tgt = strobe_en ? sw_decode(cs_filt_r) : 3'b000;
   assign keep = sw_now & sw_tgt;

   // Break-before-make: open what must open, wait the dead time, then close
   always @(posedge mclk_i) begin
      if (reset_i) begin
         cathode_switch_a_o <= 1'b0;
         cathode_switch_b_o <= 1'b0;
         cathode_switch_c_o <= 1'b0;
         bbm_cnt_r <= 8'h00;
         pend_sel_r <= 2'h0;
      end else if (!strobe_en) begin
         // Power-down opens everything immediately, ahead of discharge; on a fault both happen at the same edge
         {cathode_switch_c_o, cathode_switch_b_o, cathode_switch_a_o} <= 3'b000;
         bbm_cnt_r <= 8'h00;
         pend_sel_r <= 2'h0;
      end else if (sw_tgt != sw_now) begin
         if ((sw_now & ~sw_tgt) != 3'b000) begin
            {cathode_switch_c_o, cathode_switch_b_o, cathode_switch_a_o} <= keep;
            bbm_cnt_r <= 8'h00;
         end else if (bbm_cnt_r >= dead_time_r) begin
            {cathode_switch_c_o, cathode_switch_b_o, cathode_switch_a_o} <= sw_tgt;
            pend_sel_r <= cs_filt_r;
            bbm_cnt_r <= 8'h00;
         end else begin
            bbm_cnt_r <= bbm_cnt_r + 8'h01;
         end
      end else begin
         bbm_cnt_r <= 8'h00;
         pend_sel_r <= cs_filt_r;
      end
   end

   // Read follows the filtered select, so the new code is ready when its switch closes
   assign mem_rd_addr = (cs_filt_r == 2'h0) ? 2'h0 : cs_filt_r - 2'h1;
   assign mem_wr = cfg_wr_i && (cfg_addr_i <= `RSC_REG_CODE_C);

   rsc_code_mem #(
      .WIDTH(CODE_W),
      .DEPTH(3)
   ) u_code_mem (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .wr_en_i(mem_wr),
      .wr_addr_i(cfg_addr_i[1:0]),
      .wr_data_i(cfg_wdata_i[CODE_W-1:0]),
      .rd_addr_i(mem_rd_addr),
      .rd_data_o(mem_rd)
   );

   // DAC gets the code of the closed switch; none while all are open
   always @(posedge mclk_i) begin
      if (reset_i) begin
         led_dac_code_o <= {CODE_W{1'b0}};
         led_dac_en_o <= 1'b0;
         vled_default_o <= 1'b1;
      end else begin
         if (sw_now != 3'b000 && pend_sel_r != 2'h0) begin
            led_dac_code_o <= mem_rd;
            led_dac_en_o <= 1'b1;
            vled_default_o <= 1'b0;
         end else begin
            led_dac_code_o <= {CODE_W{1'b0}};
            led_dac_en_o <= 1'b0;
            vled_default_o <= 1'b1;
         end
      end
   end

   // Dead time register and read port; codes read back through the memory are
   // not exposed, status shows sequencer state instead
   always @(posedge mclk_i) begin
      if (reset_i) begin
         dead_time_r <= `RSC_DEAD_TIME_RST;
         cfg_rdata_o <= 16'h0000;
      end else begin
         if (cfg_wr_i && cfg_addr_i == `RSC_REG_DEAD_TIME) begin
            dead_time_r <= cfg_wdata_i[7:0];
         end
         if (cfg_rd_i) begin
            case (cfg_addr_i)
               `RSC_REG_DEAD_TIME: cfg_rdata_o <= {8'h00, dead_time_r};
               `RSC_REG_STATUS: cfg_rdata_o <= {13'h0000, strobe_en, fault_r,
                                                (state_r == S_ON)};
               default: cfg_rdata_o <= 16'h0000;
            endcase
         end
      end
   end
endmodule

// ---- sim/rsc_ctrl_model.sv ----
// Display controller model stepping the color select code
`timescale 1ns/100ps
module rsc_ctrl_model #(
   parameter HOLD = 40
) (
   input wire mclk_i,
   input wire run_i,
   output logic [1:0] color_select_o
);
   int cnt = 0;
   initial color_select_o = 2'h0;
   // Red, green, blue, then red again; code 0 while stopped
   always @(posedge mclk_i) begin
      cnt <= (!run_i || cnt == HOLD - 1) ? 0 : cnt + 1;
      if (!run_i) begin
         color_select_o <= #1 2'h0;
      end else if (cnt == HOLD - 1) begin
         color_select_o <= #1 (color_select_o == 2'h3) ? 2'h1 : color_select_o + 2'h1;
      end
   end
endmodule

// ---- sim/rsc_top_asserts.sv ----
// Concurrent checks on the rail sequencer and color strobe ports
`timescale 1ns/100ps
module rsc_top_asserts #(
   parameter CODE_W = 10
) (
   input wire mclk_i,
   input wire reset_i,
   input wire [3:0] rail_fault_i,
   input wire mirror_offset_rail_o,
   input wire mirror_bias_rail_o,
   input wire mirror_reset_rail_o,
   input wire rail_discharge_o,
   input wire cathode_switch_a_o,
   input wire cathode_switch_b_o,
   input wire cathode_switch_c_o,
   input wire [CODE_W-1:0] led_dac_code_o,
   input wire led_dac_en_o,
   input wire vled_default_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   // Collapsed views of the switches and rails
   wire all_open = !cathode_switch_a_o && !cathode_switch_b_o && !cathode_switch_c_o;
   wire rails_up = mirror_offset_rail_o && mirror_bias_rail_o && mirror_reset_rail_o;
   sequence s_sw_opened;
      $rose(all_open);
   endsequence
   sequence s_dead_gap;
      all_open ##1 all_open;
   endsequence
   property p_bbm_gap;
      s_sw_opened |-> s_dead_gap;
   endproperty
   a_bbm_gap: assert property (p_bbm_gap) else $error("no dead time");
   property p_rails_first;
      !all_open |-> rails_up;
   endproperty
   a_rails_first: assert property (p_rails_first) else $error("switch before rails");
   property p_one_closed;
      $onehot0({cathode_switch_c_o, cathode_switch_b_o, cathode_switch_a_o});
   endproperty
   a_one_closed: assert property (p_one_closed) else $error("two switches closed");
   property p_default_target;
      all_open [*2] |-> vled_default_o;
   endproperty
   a_default_target: assert property (p_default_target) else $error("no default");
   property p_no_code;
      all_open [*3] |-> !led_dac_en_o && led_dac_code_o == '0;
   endproperty
   a_no_code: assert property (p_no_code) else $error("code routed while open");
   property p_live_code;
      !all_open [*3] |-> led_dac_en_o;
   endproperty
   a_live_code: assert property (p_live_code) else $error("code not routed");
   property p_fast_down;
      rail_fault_i != 4'h0 |=> !mirror_offset_rail_o && !mirror_bias_rail_o && rail_discharge_o;
   endproperty
   a_fast_down: assert property (p_fast_down) else $error("fault left rails on");
   property p_pair_rails;
      mirror_bias_rail_o == mirror_reset_rail_o;
   endproperty
   a_pair_rails: assert property (p_pair_rails) else $error("bias and reset apart");
   property p_open_before_off;
      $fell(mirror_offset_rail_o) && rail_fault_i == 4'h0 |-> all_open;
   endproperty
   a_open_before_off: assert property (p_open_before_off) else $error("closed at off");
endmodule
bind rsc_top rsc_top_asserts #(.CODE_W(CODE_W)) u_chk (.mclk_i(mclk_i), .reset_i(reset_i),
   .rail_fault_i(rail_fault_i), .mirror_offset_rail_o(mirror_offset_rail_o),
   .mirror_bias_rail_o(mirror_bias_rail_o), .mirror_reset_rail_o(mirror_reset_rail_o),
   .rail_discharge_o(rail_discharge_o), .cathode_switch_a_o(cathode_switch_a_o),
   .cathode_switch_b_o(cathode_switch_b_o), .cathode_switch_c_o(cathode_switch_c_o),
   .led_dac_code_o(led_dac_code_o), .led_dac_en_o(led_dac_en_o),
   .vled_default_o(vled_default_o));

// ---- sim/rsc_top_tb.sv ----
// Self-checking bench for the rail sequencer and color strobe block
`timescale 1ns/100ps
`include "rsc_defs.vh"
module rsc_top_tb;
   // Short counts keep the run brief
   localparam int INIT = 20, BIAS = 50, DG = 10, STEP = 5;
   logic mclk = 1'b0, rst = 1'b1, req = 1'b0, run = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [3:0] fault = 4'h0;
   logic [1:0] tb_sel = 2'h0;
   logic [7:0] addr = 8'h00;
   logic [15:0] wdata = 16'h0000;
   wire [1:0] msel;
   wire [15:0] rdata;
   wire init, ofs, bias, rrail, disch, sa, sb, sc, dac_en, vdef;
   wire [9:0] dac;
   wire [2:0] sw = {sc, sb, sa};
   int n_fail = 0;
   int n_compared = 0;
   rsc_top #(.INIT_CYC(INIT), .BIAS_CYC(BIAS), .PWR_DG_CYC(DG), .STEP_CYC(STEP)) u_dut (
      .mclk_i(mclk), .reset_i(rst), .power_request_i(req), .rail_fault_i(fault),
      .color_select_i(run ? msel : tb_sel), .cfg_wr_i(wr), .cfg_rd_i(rd), .cfg_addr_i(addr),
      .cfg_wdata_i(wdata), .cfg_rdata_o(rdata), .mirror_init_o(init),
      .mirror_offset_rail_o(ofs), .mirror_bias_rail_o(bias), .mirror_reset_rail_o(rrail),
      .rail_discharge_o(disch), .cathode_switch_a_o(sa), .cathode_switch_b_o(sb),
      .cathode_switch_c_o(sc), .led_dac_code_o(dac), .led_dac_en_o(dac_en),
      .vled_default_o(vdef));
   rsc_ctrl_model #(.HOLD(40)) u_ctrl (.mclk_i(mclk), .run_i(run), .color_select_o(msel));
   initial begin
      forever #20 mclk = ~mclk;
   end
   // Inputs move 1 ns after the edge
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Strobes drop for a cycle so back-to-back calls never reassign in one step;
   // inputs move away from the sampling edge, as the controller does
   task automatic cfg_wr(input logic [7:0] a, input logic [15:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      tick(1);
      wr = 1'b0;
      tick(1);
   endtask
   task automatic cfg_rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
      addr = a;
      rd = 1'b1;
      tick(1);
      rd = 1'b0;
      tick(1);
      chk(nm, rdata, exp);
   endtask
   task automatic wait_sw(input logic [2:0] exp);
      for (int k = 0; k < 80 && sw !== exp; k++) tick(1);
      tick(3);
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic t_regs();
      cfg_rd(`RSC_REG_DEAD_TIME, 16'h0001, "dead_rst");
      cfg_wr(`RSC_REG_CODE_A, 16'h0155);
      cfg_wr(`RSC_REG_CODE_B, 16'h02AA);
      cfg_wr(`RSC_REG_CODE_C, 16'h03FF);
      cfg_rd(`RSC_REG_CODE_A, 16'h0000, "code_wo");
      cfg_rd(8'h20, 16'h0000, "unmapped");
      cfg_wr(`RSC_REG_DEAD_TIME, 16'h0006);
      cfg_rd(`RSC_REG_DEAD_TIME, 16'h0006, "dead_rw");
   endtask
   // Counts the init and bias phases and watches for early switch closure
   task automatic power_up();
      int k;
      logic early;
      early = 1'b0;
      req = 1'b1;
      for (k = 0; k < 60 && !init; k++) tick(1);
      chk("init_start", init, 1'b1);
      for (k = 0; k < 300 && !bias; k++) begin
         if (ofs) chk("ofs_after_init", {init, 15'(k >= INIT)}, 16'h0001);
         early = early | (sw != 3'h0);
         if (!ofs) chk("init_len", 16'(k < INIT), 16'h1);
         tick(1);
      end
      chk("bias_delay", 16'(k), 16'(INIT + BIAS));
      chk("reset_rail", rrail, 1'b1);
      chk("early_switch", early, 1'b0);
   endtask
   task automatic t_decode();
      logic [9:0] codes [4] = '{10'h000, 10'h155, 10'h2AA, 10'h3FF};
      logic [2:0] sws [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
      for (int i = 3; i >= 0; i--) begin
         tb_sel = 2'(i);
         wait_sw(sws[i]);
         chk("switches", sw, sws[i]);
         chk("dac_code", dac, codes[i]);
         chk("vled_default", vdef, i == 0);
         chk("dac_en", dac_en, i != 0);
      end
      cfg_rd(`RSC_REG_STATUS, 16'h0005, "status_up");
   endtask
   task automatic t_bbm();
      int k;
      tb_sel = 2'h1;
      wait_sw(3'h1);
      tb_sel = 2'h2;
      for (k = 0; k < 40 && sa; k++) tick(1);
      for (k = 0; k < 40 && sw === 3'h0; k++) tick(1);
      chk("dead_gap", 16'(k), 16'h0007);
      chk("after_gap", sw, 3'h2);
   endtask
   task automatic t_rotate();
      logic [2:0] seen;
      seen = 3'h0;
      run = 1'b1;
      repeat (300) begin
         tick(1);
         seen = seen | sw;
      end
      run = 1'b0;
      chk("rotation", seen, 3'h7);
   endtask
   task automatic t_down();
      int k;
      req = 1'b0;
      for (k = 0; k < 60 && bias; k++) tick(1);
      chk("open_at_down", sw, 3'h0);
      for (k = 0; k < 40 && ofs; k++) tick(1);
      chk("ofs_step", 16'(k), 16'(STEP));
      chk("discharge", disch, 1'b1);
      tick(30);
   endtask
   task automatic t_fault();
      int k;
      tb_sel = 2'h3;
      power_up();
      wait_sw(3'h4);
      fault = 4'h2;
      tick(1);
      chk("fast_down", {ofs, bias, rrail, disch}, 4'h1);
      chk("fault_open", sw, 3'h0);
      fault = 4'h0;
      tick(5);
      chk("fault_latch", {ofs, bias, rrail, disch}, 4'h1);
      cfg_rd(`RSC_REG_STATUS, 16'h0002, "status_fault");
      req = 1'b0;
      tick(30);
      // Request dropped while the mirror array is still initialising
      req = 1'b1;
      for (k = 0; k < 60 && !init; k++) tick(1);
      req = 1'b0;
      tick(40);
      chk("abort_init", {init, ofs, disch}, 3'h1);
   endtask
   initial begin
      tick(12);
      rst = 1'b0;
      tick(1);
      t_regs();
      tb_sel = 2'h1;
      power_up();
      t_decode();
      t_bbm();
      t_rotate();
      t_down();
      t_fault();
      give_verdict();
   end
   // Whole run is under a thousand cycles
   initial begin
      #800000;
      n_fail++;
      give_verdict();
   end
endmodule
